// *** test_usart_mode_and_irq_enable.sv ***
/* Bench for the mode and mask block with its serial peer.
   Assumes a 25 MHz hclk and a single bus master. */
`timescale 1ns/100ps
module test_usart_mode_and_irq_enable;
  reg hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  reg [7:0] haddr = 8'h00;
  reg [1:0] htrans = 2'h0;
  reg [2:0] hsize = 3'h2;
  reg [31:0] hwdata = 32'h0000_0000;
  reg [19:0] irq_status_in = 20'h0_0000;
  reg tx_serial_in = 1'h1, bit_clk_in = 1'h0, sample_tick = 1'h0;
  reg rx_char_done = 1'h0, rx_parity_err = 1'h0, reset_iter = 1'h0;
  reg line_en = 1'h0, line_bit = 1'h1, sck_drive = 1'h0;
  integer failures = 0, samples_checked = 0, i;
  wire [31:0] hrdata;
  wire hready, hreadyout, hresp, irq_out, rxd_pin, sck_in, txd_out, sck_oe, rx_serial_out;
  wire nack_req, iteration_flag, mode_modem, mode_reserved, sync_mode, parity_en, msb_first;
  wire sck_out, sck_sync, mode_normal, mode_rs485, mode_handshake, mode_iso_t0, mode_iso_t1;
  wire mode_irda, clk_use_div, clk_use_ext, clk_reserved, parity_odd, parity_forced;
  wire parity_force_val, multidrop, stop_reserved;
  wire [3:0] char_bits;
  wire [2:0] stop_halves;
  wire [4:0] samples_per_bit;
  wire [2:0] max_iter;
  wire [5:0] mode_bits = {mode_irda, mode_iso_t1, mode_iso_t0, mode_handshake, mode_rs485,
    mode_normal};
  wire [5:0] par_bits = {stop_reserved, parity_forced, parity_force_val, parity_odd,
    multidrop, parity_en};
  wire [2:0] clk_bits = {clk_reserved, clk_use_ext, clk_use_div};
  assign hready = hreadyout;
  umie_top i_umie_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
    .hwdata, .hrdata, .hreadyout, .hresp, .irq_status_in, .irq_out, .rxd_pin, .txd_out,
    .sck_in, .sck_out, .sck_oe, .tx_serial_in, .rx_serial_out, .bit_clk_in, .sample_tick,
    .sck_sync, .rx_char_done, .rx_parity_err, .reset_iter, .nack_req, .iteration_flag,
    .mode_normal, .mode_rs485, .mode_handshake, .mode_modem, .mode_iso_t0, .mode_iso_t1,
    .mode_irda, .mode_reserved, .clk_use_div, .clk_use_ext, .clk_reserved, .char_bits,
    .sync_mode, .parity_en, .parity_odd, .parity_forced, .parity_force_val, .multidrop,
    .stop_halves, .stop_reserved, .msb_first, .samples_per_bit, .max_iter);
  umie_peer i_umie_peer (.line_en, .line_bit, .sck_drive, .rxd_pin, .sck_in);
  initial begin
    forever #20 hclk = ~hclk;
  end
  task report_and_stop;
    begin
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge hclk);
  endtask
  // Ready is sampled at the edge, before that edge's updates land
  task wt;
    integer n;
    begin
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'h1 && n < 20) begin
        n = n + 1;
        @(posedge hclk);
      end
      if (hreadyout !== 1'h1) begin
        failures = failures + 1;
        report_and_stop;
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      hsel <= 1'h1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= 1'h1;
      wt;
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      wt;
    end
  endtask
  task rc(input [7:0] a, input [31:0] e);
    begin
      hsel <= 1'h1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= 1'h0;
      wt;
      hsel <= 1'h0;
      htrans <= 2'h0;
      wt;
      chk(hrdata, e);
    end
  endtask
  task mr(input [31:0] v);
    begin
      wr(8'h04, v);
      cyc(3);
    end
  endtask
  task ev(input e, input n);
    begin
      rx_char_done <= 1'h1;
      rx_parity_err <= e;
      @(posedge hclk);
      rx_char_done <= 1'h0;
      @(posedge hclk);
      chk(nack_req, n);
      cyc(2);
    end
  endtask
  task tick;
    begin
      sample_tick <= 1'h1;
      @(posedge hclk);
      sample_tick <= 1'h0;
      cyc(4);
    end
  endtask
  task t_mask;
    begin
      wr(8'h08, 32'hFFFF_FFFF);
      rc(8'h10, 32'h000F_3FFF);
      wr(8'h0C, 32'h0000_0101);
      rc(8'h10, 32'h000F_3EFE);
      wr(8'h08, 32'h0000_0000);
      rc(8'h10, 32'h000F_3EFE);
      rc(8'h08, 32'h0000_0000);
      rc(8'h40, 32'h0000_0000);
      chk(hresp, 1'h0);
      irq_status_in <= 20'h0_0001;
      cyc(3);
      chk(irq_out, 1'h0);
      irq_status_in <= 20'h8_0000;
      cyc(3);
      chk(irq_out, 1'h1);
      wr(8'h0C, 32'h0008_0000);
      cyc(3);
      chk(irq_out, 1'h0);
      irq_status_in <= 20'h0_0000;
    end
  endtask
  task t_modes;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        mr(i);
        chk(mode_reserved, i == 5 || i == 7 || i > 8);
        chk(mode_modem, i == 3);
        chk(mode_bits, {i == 8, i == 6, i == 4, i == 2, i == 1, i == 0});
        rc(8'h04, i);
      end
    end
  endtask
  task t_frame;
    begin
      mr(32'h0000_1040);
      chk(char_bits, 4'h6);
      chk(stop_halves, 3'h3);
      chk(parity_en, 1'h1);
      mr(32'h000A_1940);
      chk(char_bits, 4'h9);
      chk(samples_per_bit, 5'h08);
      chk(sync_mode, 1'h1);
      chk(stop_halves, 3'h2);
      chk(stop_reserved, 1'h1);
      chk(parity_en, 1'h0);
      mr(32'h0001_0103);
      chk(sync_mode, 1'h0);
      chk(msb_first, 1'h1);
      mr(32'h0000_3600);
      chk(par_bits, 6'h39);
      mr(32'h0000_0E00);
      chk(par_bits, 6'h02);
      mr(32'h0000_0200);
      chk(par_bits, 6'h05);
      mr(32'h0004_0010);
      chk(sck_oe, 1'h1);
      chk(clk_bits, 3'h1);
      mr(32'h0004_0020);
      chk(sck_oe, 1'h1);
      chk(clk_bits, 3'h4);
      mr(32'h0004_0030);
      chk(sck_oe, 1'h0);
      chk(clk_bits, 3'h2);
      bit_clk_in <= 1'h1;
      cyc(2);
      chk(sck_out, 1'h1);
      bit_clk_in <= 1'h0;
      mr(32'hFFFF_FFFF);
      rc(8'h04, 32'h173F_FFFF);
    end
  endtask
  task t_nack;
    begin
      mr(32'h0220_0004);
      chk(max_iter, 3'h2);
      ev(1'h1, 1'h1);
      ev(1'h1, 1'h1);
      ev(1'h1, 1'h0);
      chk(iteration_flag, 1'h1);
      reset_iter <= 1'h1;
      @(posedge hclk);
      reset_iter <= 1'h0;
      cyc(2);
      chk(iteration_flag, 1'h0);
      // A good character in between restarts the successive count
      mr(32'h0120_0004);
      ev(1'h1, 1'h1);
      ev(1'h0, 1'h0);
      ev(1'h1, 1'h1);
      ev(1'h1, 1'h0);
      mr(32'h0000_0006);
      for (i = 0; i < 3; i = i + 1)
        ev(1'h1, 1'h1);
      mr(32'h0010_0004);
      ev(1'h1, 1'h0);
      mr(32'h0000_0000);
      ev(1'h1, 1'h0);
    end
  endtask
  task t_line;
    begin
      line_en <= 1'h1;
      line_bit <= 1'h0;
      // Both transmitter levels, so a copied path differs from the idle level
      for (i = 0; i < 8; i = i + 1) begin
        tx_serial_in <= i[2];
        mr((i % 4) << 14);
        cyc(2);
        chk(txd_out, (i % 4 == 0) ? i[2] : (i % 4 == 2));
        chk(rx_serial_out, (i % 4 == 2) ? i[2] : (i % 4 == 3));
      end
      tx_serial_in <= 1'h1;
      sck_drive <= 1'h1;
      cyc(3);
      chk(sck_sync, 1'h1);
      sck_drive <= 1'h0;
      // Filter starts all ones, so one low sample is outvoted
      mr(32'h1000_0000);
      cyc(2);
      chk(rx_serial_out, 1'h1);
      tick;
      chk(rx_serial_out, 1'h1);
      tick;
      chk(rx_serial_out, 1'h0);
    end
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_mask;
    t_modes;
    t_frame;
    t_nack;
    t_line;
    report_and_stop;
  end
endmodule

// *** umie_asserts.sv ***
/* Checker for the mode and interrupt mask block.
   Assumes it is bound onto umie_top, one hclk domain. */
`timescale 1ns/100ps
module umie_asserts (
  // Clock, reset, bus
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  // Interrupt and decodes
  input wire [19:0] irq_status_in,
  input wire irq_out,
  input wire sck_oe,
  input wire clk_use_ext,
  input wire [3:0] char_bits,
  input wire [4:0] samples_per_bit,
  input wire sync_mode,
  input wire [2:0] stop_halves,
  input wire mode_modem,
  // Smart card
  input wire mode_iso_t0,
  input wire mode_iso_t1,
  input wire rx_char_done,
  input wire rx_parity_err,
  input wire nack_req,
  input wire iteration_flag
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence bad_char;
    rx_char_done && rx_parity_err && (mode_iso_t0 || mode_iso_t1);
  endsequence
  sequence rd_req;
    hsel && htrans[1] && !hwrite && hready;
  endsequence
  // Status is sampled one cycle ahead, so look back one edge
  irq_cause_a: assert property (irq_out |-> $past(|irq_status_in))
    else $error("irq without status");
  clk_pin_a: assert property (sck_oe |-> !clk_use_ext)
    else $error("clock pin driven");
  len_range_a: assert property (char_bits inside {[4'h5:4'h9]})
    else $error("bad length");
  ovs_pair_a: assert property (samples_per_bit == 5'h10 || samples_per_bit == 5'h08)
    else $error("bad oversampling");
  sync_stop_a: assert property (sync_mode |-> stop_halves != 3'h3)
    else $error("half stop in sync");
  modem_async_a: assert property (mode_modem |-> !sync_mode)
    else $error("modem not async");
  nack_cause_a: assert property (nack_req |-> $past(rx_char_done && rx_parity_err))
    else $error("nack without error");
  iter_stop_a: assert property (bad_char ##1 $rose(iteration_flag) |-> !nack_req)
    else $error("nack at limit");
  rd_wait_a: assert property (rd_req |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
endmodule
bind umie_top umie_asserts i_umie_asserts (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .irq_status_in, .irq_out, .sck_oe, .clk_use_ext, .char_bits,
  .samples_per_bit, .sync_mode, .stop_halves, .mode_modem, .mode_iso_t0, .mode_iso_t1,
  .rx_char_done, .rx_parity_err, .nack_req, .iteration_flag);

// *** umie_map.vh ***
/*
  Constants for the serial port mode and interrupt-mask block.
  Assumes inclusion by bare name from the design file of the same folder.
*/
`ifndef UMIE_MAP_VH
`define UMIE_MAP_VH

// Register byte offsets
`define UMIE_OFS_MODE 8'h04
`define UMIE_OFS_IEN_SET 8'h08
`define UMIE_OFS_IEN_CLR 8'h0C
`define UMIE_OFS_IMASK 8'h10

// Writable bits and reset values
`define UMIE_MODE_WMASK 32'h173F_FFFF
`define UMIE_MODE_RST 32'h0000_0000
`define UMIE_IRQ_BITS 20
`define UMIE_IRQ_VALID 20'hF_3FFF
`define UMIE_IRQ_RST 20'h0_0000

// Field positions inside the mode register
`define UMIE_F_MODE 3:0
`define UMIE_F_CLKS 5:4
`define UMIE_F_CHAR_LENGTH_FIELD 7:6
`define UMIE_B_SYNC 8
`define UMIE_F_PAR 11:9
`define UMIE_F_STOP 13:12
`define UMIE_F_CHANNEL_PATH_MODE 15:14
`define UMIE_B_BIT_ORDER_SELECT 16
`define UMIE_B_NINE 17
`define UMIE_B_CKOUT 18
`define UMIE_B_OVER 19
`define UMIE_B_INHIBIT_NEGATIVE_ACK 20
`define UMIE_B_SUCCESSIVE_NACK_DISABLE 21
`define UMIE_F_MAXIT 26:24
`define UMIE_B_FILTER 28

// Operating mode codes
`define UMIE_M_NORMAL 4'h0
`define UMIE_M_RS485 4'h1
`define UMIE_M_HSHAKE 4'h2
`define UMIE_M_MODEM 4'h3
`define UMIE_M_ISO_T0 4'h4
`define UMIE_M_ISO_T1 4'h6
`define UMIE_M_IRDA 4'h8

// Clock source, stop and channel codes
`define UMIE_CK_MAIN 2'h0
`define UMIE_CK_DIV 2'h1
`define UMIE_CK_EXT 2'h3
`define UMIE_ST_ONE 2'h0
`define UMIE_ST_HALF 2'h1
`define UMIE_ST_TWO 2'h2
`define UMIE_CH_NORMAL 2'h0
`define UMIE_CH_ECHO 2'h1
`define UMIE_CH_LOCAL 2'h2
`define UMIE_CH_REMOTE 2'h3

// Derived figures
`define UMIE_LEN_BASE 4'h5
`define UMIE_LEN_NINE 4'h9
`define UMIE_HALVES_ONE 3'h2
`define UMIE_HALVES_HALF 3'h3
`define UMIE_HALVES_TWO 3'h4
`define UMIE_OVS_16 5'h10
`define UMIE_OVS_8 5'h08
`define UMIE_LINE_IDLE 1'b1
`define UMIE_FILT_RST 3'h7
`define UMIE_CNT_RST 3'h0
`define UMIE_CNT_ONE 3'h1
`define UMIE_ZERO32 32'h0000_0000

`endif

// *** umie_peer.sv ***
/* Serial peer on the line pins.
   Assumes the bench chooses when it sends and what level. */
`timescale 1ns/100ps
module umie_peer (
  // Control from the bench
  input wire line_en,
  input wire line_bit,
  input wire sck_drive,
  // Pins
  output wire rxd_pin,
  output wire sck_in
);
  // A released line rests at mark, as its pull-up would leave it
  assign rxd_pin = line_en ? line_bit : 1'h1;
  // Clock pin level is set by the bench; it stands still outside frames
  assign sck_in = sck_drive;
endmodule

// *** umie_top.v ***
/*
  Mode configuration and interrupt mask logic of a serial port, with an
  AHB-Lite register slave, line path selection, receive filter and the
  smart-card negative-acknowledge decision.
  Assumes the datapath, baud generator and status flags sit outside on
  hclk; only rxd_pin and sck_in come from outside the clock domain.
*/
// Overview of operation
// - Four-bit field selects operating mode
// - Clock source select; drive clock pin conditionally
// - Character length 5 to 8, or nine
// - Sync bit chooses asynchronous or synchronous framing
// - Three-bit parity field decodes parity kind
// - Stop bits one, one and half, two
// - Channel mode routes echo and loopback paths
// - Bit order selects LSB or MSB first
// - Oversampling sixteen or eight per bit
// - Inhibit bit suppresses negative acknowledge
// - Without disable, NACK on each parity error
// - With disable, count errors, NACK each
// - At maximum stop NACK, set iteration flag
// - Bits 26:24 hold maximum repetitions
// - Optional three-sample majority receive filter
// - Enable register sets mask bits on ones
// - Disable register clears mask bits on ones
// - Interrupt sources at fixed bit positions
// - Mode register field placement
// - Mask register reads enabled interrupts
// - Modem mode behaves as asynchronous
`timescale 1ns/100ps
`include "umie_map.vh"

module umie_top (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Status flags and interrupt
  input wire [19:0] irq_status_in,
  output reg irq_out,
  // Serial pins
  input wire rxd_pin,
  output reg txd_out,
  input wire sck_in,
  output reg sck_out,
  output reg sck_oe,
  // Datapath side of the line
  input wire tx_serial_in,
  output reg rx_serial_out,
  input wire bit_clk_in,
  input wire sample_tick,
  output reg sck_sync,
  // Smart-card receive events
  input wire rx_char_done,
  input wire rx_parity_err,
  input wire reset_iter,
  output reg nack_req,
  output reg iteration_flag,
  // Decoded operating mode
  output reg mode_normal,
  output reg mode_rs485,
  output reg mode_handshake,
  output reg mode_modem,
  output reg mode_iso_t0,
  output reg mode_iso_t1,
  output reg mode_irda,
  output reg mode_reserved,
  // Decoded clock source
  output reg clk_use_div,
  output reg clk_use_ext,
  output reg clk_reserved,
  // Decoded framing
  output reg [3:0] char_bits,
  output reg sync_mode,
  output reg parity_en,
  output reg parity_odd,
  output reg parity_forced,
  output reg parity_force_val,
  output reg multidrop,
  output reg [2:0] stop_halves,
  output reg stop_reserved,
  output reg msb_first,
  output reg [4:0] samples_per_bit,
  output reg [2:0] max_iter
);

  reg [31:0] mode_reg;
  reg [19:0] irq_mask;
  reg wr_pend;
  reg rd_pend;
  reg [7:0] dp_addr;
  reg rxd_s1;
  reg rxd_s2;
  reg sck_s1;
  reg [2:0] filt;
  reg [2:0] err_cnt;
  wire acc;
  wire [3:0] mfield;
  wire [1:0] cfield;
  wire [1:0] stfield;
  wire [2:0] pfield;
  wire eff_sync;
  wire iso;
  wire maj;
  wire rx_line;
  wire iter_set;
  wire iter_clr;
  reg [31:0] rd_val;
  // Per-bit views of the mask constants, so each flop takes exactly one bit
  localparam [19:0] irq_valid = `UMIE_IRQ_VALID;
  localparam [19:0] irq_rst = `UMIE_IRQ_RST;

  assign acc = hsel & htrans[1] & hready;
  assign mfield = mode_reg[`UMIE_F_MODE];
  assign cfield = mode_reg[`UMIE_F_CLKS];
  assign stfield = mode_reg[`UMIE_F_STOP];
  assign pfield = mode_reg[`UMIE_F_PAR];
  // Modem mode forces asynchronous framing
  assign eff_sync = mode_reg[`UMIE_B_SYNC] & (mfield != `UMIE_M_MODEM);
  assign iso = (mfield == `UMIE_M_ISO_T0) | (mfield == `UMIE_M_ISO_T1);

  // Bus phases: writes complete with no wait, reads take one wait state
  // so that a read right after a write sees the committed value.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      dp_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= `UMIE_ZERO32;
    end else begin
      hresp <= 1'b0;
      if (rd_pend) begin
        rd_pend <= 1'b0;
        hreadyout <= 1'b1;
        hrdata <= rd_val;
      end else begin
        wr_pend <= acc & hwrite;
        rd_pend <= acc & ~hwrite;
        hreadyout <= ~(acc & ~hwrite);
        if (acc) begin
          dp_addr <= {haddr[7:2], 2'b00};
        end
      end
    end
  end

  always @* begin
    rd_val = `UMIE_ZERO32;
    case (dp_addr)
      `UMIE_OFS_MODE: rd_val = mode_reg;
      `UMIE_OFS_IMASK: rd_val = {12'h000, irq_mask};
      default: rd_val = `UMIE_ZERO32;
    endcase
  end

  // Mode register; unused bits stay zero
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= `UMIE_MODE_RST;
    end else if (wr_pend && dp_addr == `UMIE_OFS_MODE) begin
      mode_reg <= hwdata & `UMIE_MODE_WMASK;
    end
  end

  // One flop per interrupt source; holes in the map never set
  genvar gi;
  generate
    for (gi = 0; gi < `UMIE_IRQ_BITS; gi = gi + 1) begin : g_mask
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          irq_mask[gi] <= irq_rst[gi];
        end else if (wr_pend && irq_valid[gi]) begin
          if (dp_addr == `UMIE_OFS_IEN_SET && hwdata[gi]) begin
            irq_mask[gi] <= 1'b1;
          end else if (dp_addr == `UMIE_OFS_IEN_CLR && hwdata[gi]) begin
            irq_mask[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status_in & irq_mask);
    end
  end

  // Pin synchronisers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxd_s1 <= `UMIE_LINE_IDLE;
      rxd_s2 <= `UMIE_LINE_IDLE;
      sck_s1 <= 1'b0;
      sck_sync <= 1'b0;
    end else begin
      rxd_s1 <= rxd_pin;
      rxd_s2 <= rxd_s1;
      sck_s1 <= sck_in;
      sck_sync <= sck_s1;
    end
  end

  // Majority filter samples on the sixteenth-bit tick from the baud logic
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt <= `UMIE_FILT_RST;
    end else if (sample_tick) begin
      filt <= {filt[1:0], rxd_s2};
    end
  end

  assign maj = (filt[0] & filt[1]) | (filt[1] & filt[2]) | (filt[0] & filt[2]);
  assign rx_line = mode_reg[`UMIE_B_FILTER] ? maj : rxd_s2;

  // Line path; each path costs one cycle of latency
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd_out <= `UMIE_LINE_IDLE;
      rx_serial_out <= `UMIE_LINE_IDLE;
    end else begin
      case (mode_reg[`UMIE_F_CHANNEL_PATH_MODE])
        `UMIE_CH_NORMAL: begin
          txd_out <= tx_serial_in;
          rx_serial_out <= rx_line;
        end
        `UMIE_CH_ECHO: begin
          txd_out <= rx_line;
          rx_serial_out <= rx_line;
        end
        `UMIE_CH_LOCAL: begin
          txd_out <= `UMIE_LINE_IDLE;
          rx_serial_out <= tx_serial_in;
        end
        default: begin
          txd_out <= rx_line;
          rx_serial_out <= `UMIE_LINE_IDLE;
        end
      endcase
    end
  end

  // Clock pin is driven only when the clock is not taken from it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_oe <= 1'b0;
      sck_out <= 1'b0;
    end else begin
      sck_oe <= mode_reg[`UMIE_B_CKOUT] & (cfield != `UMIE_CK_EXT);
      sck_out <= bit_clk_in;
    end
  end

  // Smart-card negative acknowledge and successive error count
  assign iter_set = iso & rx_char_done & rx_parity_err & ~mode_reg[`UMIE_B_INHIBIT_NEGATIVE_ACK] &
    mode_reg[`UMIE_B_SUCCESSIVE_NACK_DISABLE] & (err_cnt == mode_reg[`UMIE_F_MAXIT]);
  assign iter_clr = iso & reset_iter;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nack_req <= 1'b0;
      err_cnt <= `UMIE_CNT_RST;
    end else begin
      nack_req <= 1'b0;
      if (iter_clr) begin
        err_cnt <= `UMIE_CNT_RST;
      end else if (iso && rx_char_done) begin
        if (!rx_parity_err) begin
          err_cnt <= `UMIE_CNT_RST;
        end else if (mode_reg[`UMIE_B_INHIBIT_NEGATIVE_ACK]) begin
          nack_req <= 1'b0;
        end else if (!mode_reg[`UMIE_B_SUCCESSIVE_NACK_DISABLE]) begin
          nack_req <= 1'b1;
        end else if (err_cnt != mode_reg[`UMIE_F_MAXIT]) begin
          nack_req <= 1'b1;
          err_cnt <= err_cnt + `UMIE_CNT_ONE;
        end
      end
    end
  end

  // A new maximum in the clearing cycle keeps the flag set
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      iteration_flag <= 1'b0;
    end else begin
      iteration_flag <= iter_set | (iteration_flag & ~iter_clr);
    end
  end

  // Decoded configuration, registered so every output is a flop
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_normal <= 1'b1;
      mode_rs485 <= 1'b0;
      mode_handshake <= 1'b0;
      mode_modem <= 1'b0;
      mode_iso_t0 <= 1'b0;
      mode_iso_t1 <= 1'b0;
      mode_irda <= 1'b0;
      mode_reserved <= 1'b0;
      clk_use_div <= 1'b0;
      clk_use_ext <= 1'b0;
      clk_reserved <= 1'b0;
      char_bits <= `UMIE_LEN_BASE;
      sync_mode <= 1'b0;
      parity_en <= 1'b1;
      parity_odd <= 1'b0;
      parity_forced <= 1'b0;
      parity_force_val <= 1'b0;
      multidrop <= 1'b0;
      stop_halves <= `UMIE_HALVES_ONE;
      stop_reserved <= 1'b0;
      msb_first <= 1'b0;
      samples_per_bit <= `UMIE_OVS_16;
      max_iter <= `UMIE_CNT_RST;
    end else begin
      mode_normal <= mfield == `UMIE_M_NORMAL;
      mode_rs485 <= mfield == `UMIE_M_RS485;
      mode_handshake <= mfield == `UMIE_M_HSHAKE;
      mode_modem <= mfield == `UMIE_M_MODEM;
      mode_iso_t0 <= mfield == `UMIE_M_ISO_T0;
      mode_iso_t1 <= mfield == `UMIE_M_ISO_T1;
      mode_irda <= mfield == `UMIE_M_IRDA;
      mode_reserved <= ~((mfield <= `UMIE_M_ISO_T0) | (mfield == `UMIE_M_ISO_T1) |
        (mfield == `UMIE_M_IRDA));
      clk_use_div <= cfield == `UMIE_CK_DIV;
      clk_use_ext <= cfield == `UMIE_CK_EXT;
      clk_reserved <= ~((cfield == `UMIE_CK_MAIN) | (cfield == `UMIE_CK_DIV) |
        (cfield == `UMIE_CK_EXT));
      if (mode_reg[`UMIE_B_NINE]) begin
        char_bits <= `UMIE_LEN_NINE;
      end else begin
        char_bits <= {2'b00, mode_reg[`UMIE_F_CHAR_LENGTH_FIELD]} + `UMIE_LEN_BASE;
      end
      sync_mode <= eff_sync;
      parity_en <= ~pfield[2];
      parity_odd <= pfield == 3'h1;
      parity_forced <= pfield[2:1] == 2'h1;
      parity_force_val <= pfield == 3'h3;
      multidrop <= pfield[2:1] == 2'h3;
      case (stfield)
        `UMIE_ST_ONE: begin
          stop_halves <= `UMIE_HALVES_ONE;
          stop_reserved <= 1'b0;
        end
        `UMIE_ST_HALF: begin
          stop_halves <= eff_sync ? `UMIE_HALVES_ONE : `UMIE_HALVES_HALF;
          stop_reserved <= eff_sync;
        end
        `UMIE_ST_TWO: begin
          stop_halves <= `UMIE_HALVES_TWO;
          stop_reserved <= 1'b0;
        end
        default: begin
          stop_halves <= `UMIE_HALVES_ONE;
          stop_reserved <= 1'b1;
        end
      endcase
      msb_first <= mode_reg[`UMIE_B_BIT_ORDER_SELECT];
      samples_per_bit <= mode_reg[`UMIE_B_OVER] ? `UMIE_OVS_8 : `UMIE_OVS_16;
      max_iter <= mode_reg[`UMIE_F_MAXIT];
    end
  end

endmodule
